// file: include/pldw_pkg.sv
// Constants, types and states shared by the page list and descriptor builder
//
// Overview of operation
// - Pointer entry: bits 63:2 address, 1:0 reserved
// - Only first entry or list pointer has offset
// - Last slot of full list page chains onward
// - List holds only entries beyond command slots
// - First list pointer qword aligned, offset allowed
// - List entries and second slot page aligned
// - Lists minimal, packed from entry zero
// - Chained list pages start on page boundary
// - Descriptor lengths cover whole transfer
// - Segment qword aligned, 16-byte descriptors packed
// - Byte 15 identifier: type high, subtype low
// - Software page size fixes offset width
package pldw_pkg;

  localparam int unsigned ENTRY_W        = 64;
  localparam int unsigned OFFSET_LSB     = 2;
  localparam int unsigned PAGE_SHIFT_MIN = 12;
  localparam int unsigned QWORD_BYTES    = 8;
  localparam int unsigned DESC_BYTES     = 16;
  localparam int unsigned DESC_LOG2      = 4;
  localparam int unsigned ID_TYPE_LSB    = 60;
  localparam int unsigned ID_SUB_LSB     = 56;

  localparam logic [1:0]  RSVD_MASK      = 2'h3;
  localparam logic [2:0]  QWORD_MASK     = 3'h7;
  localparam logic [63:0] ADDR_RESET     = 64'h0;

  // Descriptor type codes
  localparam logic [3:0]  TYPE_DATA      = 4'h0;
  localparam logic [3:0]  TYPE_DISCARD   = 4'h1;
  localparam logic [3:0]  TYPE_CHAIN     = 4'h2;
  localparam logic [3:0]  TYPE_LAST      = 4'h3;
  localparam logic [3:0]  SUB_ZERO       = 4'h0;

  // Error codes reported on completion
  localparam logic [2:0]  ERR_NONE       = 3'h0;
  localparam logic [2:0]  ERR_BUF_ALIGN  = 3'h1;
  localparam logic [2:0]  ERR_ZERO_LEN   = 3'h2;
  localparam logic [2:0]  ERR_LIST_ALIGN = 3'h3;
  localparam logic [2:0]  ERR_SEG_ALIGN  = 3'h4;
  localparam logic [2:0]  ERR_OVERFLOW   = 3'h5;

  typedef enum logic { PLDW_MODE_PAGE, PLDW_MODE_SCATTER } pldw_mode_e;

  typedef enum { PLDW_IDLE, PLDW_LIST, PLDW_SEG_LO, PLDW_SEG_HI, PLDW_FINISH } pldw_state_e;

  // One build request from the user side
  typedef struct packed {
    pldw_mode_e  mode;
    logic [63:0] buf_addr;
    logic [31:0] length;
    logic [3:0]  page_size_setting;
    logic [63:0] list_base;
    logic [63:0] seg_base;
  } pldw_req_s;

  // One qword write into host memory
  typedef struct packed {
    logic        en;
    logic [63:0] addr;
    logic [63:0] data;
  } pldw_wr_s;

endpackage

// file: verilog/pldw_mem.sv
// Qword-wide host memory image holding the built lists and segments
`timescale 1ns/100ps
`default_nettype none
module pldw_mem #(
  parameter int unsigned DATA_W = 64,
  parameter int unsigned IDX_W  = 10
) (
  // Clock
  input  wire logic              clk,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [IDX_W-1:0]  wr_idx,
  input  wire logic [DATA_W-1:0] wr_data,
  // Read port, data one cycle later
  input  wire logic              rd_en,
  input  wire logic [IDX_W-1:0]  rd_idx,
  output var  logic [DATA_W-1:0] rd_data_q
);

  logic [DATA_W-1:0] mem_q [2**IDX_W];

  // Storage array, no reset so it maps onto block RAM
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge clk)
  begin
    if (rd_en)
    begin
      rd_data_q <= mem_q[rd_idx];
    end
  end

endmodule
`default_nettype wire

// file: verilog/pldw_desc_pack.sv
// Packs one 16-byte descriptor into its low and high qwords
`timescale 1ns/100ps
`default_nettype none
module pldw_desc_pack (
  // Descriptor fields
  input  wire logic [3:0]  type_code,
  input  wire logic [3:0]  sub_code,
  input  wire logic [63:0] addr,
  input  wire logic [31:0] len,
  // Packed qwords, bytes 7:0 and 15:8
  output logic [63:0]      lo,
  output logic [63:0]      hi
);

  // Discard regions carry no address; bytes 14:12 stay reserved zero
  assign lo = (type_code == pldw_pkg::TYPE_DISCARD) ? pldw_pkg::ADDR_RESET : addr;
  assign hi = {type_code, sub_code, 24'h000000, len};

endmodule
`default_nettype wire

// file: verilog/pldw_builder.sv
// Host-side builder of page pointer lists and scatter-gather segments
`timescale 1ns/100ps
`default_nettype none
module pldw_builder #(
  parameter int unsigned MEM_IDX_W   = 10,
  parameter int unsigned CHUNK_SHIFT = 12
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // Build request
  input  wire logic                start,
  input  wire pldw_pkg::pldw_req_s req,
  // Status
  output logic                     busy_q,
  output logic                     done_q,
  output logic [2:0]               err_q,
  output logic [31:0]              count_q,
  // Command slots handed to the device
  output logic [63:0]              slot1_q,
  output logic [63:0]              slot2_q,
  // Memory readback, as the device fetches it
  input  wire logic                rd_en,
  input  wire logic [MEM_IDX_W-1:0] rd_idx,
  output logic [63:0]              rd_data_q
);

  localparam logic [63:0] CHUNK_BYTES = 64'h1 << CHUNK_SHIFT;
  localparam logic [32:0] CHUNK_MASK  = 33'(CHUNK_BYTES - 64'h1);

  pldw_pkg::pldw_state_e state_q;
  pldw_pkg::pldw_req_s   req_q;
  pldw_pkg::pldw_wr_s    wr_d;

  logic [63:0] page_q;
  logic [63:0] mask_q;
  logic [63:0] wr_addr_q;
  logic [63:0] data_addr_q;
  logic [31:0] left_q;
  logic [31:0] rem_q;

  // Start-time arithmetic on the incoming request
  logic [5:0]  shift_s;
  logic [63:0] page_s;
  logic [63:0] mask_s;
  logic [63:0] base_s;
  logic [63:0] span_s;
  logic [63:0] pages_s;
  logic [32:0] ndesc_s;
  logic [31:0] ndesc_w;
  logic [64:0] end_s;
  logic [2:0]  err_s;

  // Page size setting fixes the offset width
  assign shift_s = 6'(pldw_pkg::PAGE_SHIFT_MIN) + {2'h0, req.page_size_setting};
  assign page_s  = 64'h1 << shift_s;
  assign mask_s  = page_s - 64'h1;
  assign base_s  = req.buf_addr & ~mask_s;
  assign span_s  = (req.buf_addr & mask_s) + {32'h0, req.length};
  assign pages_s = (span_s + mask_s) >> shift_s;
  assign ndesc_s = ({1'b0, req.length} + CHUNK_MASK) >> CHUNK_SHIFT;
  assign ndesc_w = (req.length == 32'h0) ? 32'h1 : ndesc_s[31:0];
  assign end_s   = {1'b0, req.buf_addr} + {33'h0, req.length};

  // Refuse requests the device would reject; nothing is written for them
  always_comb
  begin
    err_s = pldw_pkg::ERR_NONE;
    if (req.mode == pldw_pkg::PLDW_MODE_PAGE)
    begin
      if ((req.buf_addr[1:0] & pldw_pkg::RSVD_MASK) != 2'h0)
      begin
        err_s = pldw_pkg::ERR_BUF_ALIGN;
      end
      else if (req.length == 32'h0)
      begin
        err_s = pldw_pkg::ERR_ZERO_LEN;
      end
      else if (pages_s > 64'h2 && (req.list_base[2:0] & pldw_pkg::QWORD_MASK) != 3'h0)
      begin
        err_s = pldw_pkg::ERR_LIST_ALIGN;
      end
    end
    else
    begin
      if ((req.seg_base[2:0] & pldw_pkg::QWORD_MASK) != 3'h0)
      begin
        err_s = pldw_pkg::ERR_SEG_ALIGN;
      end
      else if (end_s[64] && end_s[63:0] != 64'h0)
      begin
        err_s = pldw_pkg::ERR_OVERFLOW;
      end
    end
  end

  // List walk helpers
  logic        at_end;
  logic [63:0] next_page;
  logic [31:0] cur_len;

  // Last qword of the current list page, where a chain pointer may go
  assign at_end    = (wr_addr_q & mask_q) == (mask_q & ~64'h7);
  assign next_page = (wr_addr_q & ~mask_q) + page_q;
  assign cur_len   = ({32'h0, rem_q} > CHUNK_BYTES) ? CHUNK_BYTES[31:0] : rem_q;

  // Descriptor packers: one for segment entries, one for the command's pointer
  logic [63:0] seg_lo;
  logic [63:0] seg_hi;
  logic [63:0] cmd_lo;
  logic [63:0] cmd_hi;
  logic [31:0] seg_len_s;

  assign seg_len_s = ndesc_w << pldw_pkg::DESC_LOG2;

  pldw_desc_pack u_seg_pack (
    .type_code (pldw_pkg::TYPE_DATA),
    .sub_code  (pldw_pkg::SUB_ZERO),
    .addr      (data_addr_q),
    .len       (cur_len),
    .lo        (seg_lo),
    .hi        (seg_hi)
  );

  pldw_desc_pack u_cmd_pack (
    .type_code (pldw_pkg::TYPE_LAST),
    .sub_code  (pldw_pkg::SUB_ZERO),
    .addr      (req.seg_base),
    .len       (seg_len_s),
    .lo        (cmd_lo),
    .hi        (cmd_hi)
  );

  // Memory write chosen by the walk state
  always_comb
  begin
    wr_d = '0;
    unique case (state_q)
      pldw_pkg::PLDW_LIST:
      begin
        wr_d.en   = 1'b1;
        wr_d.addr = wr_addr_q;
        if (at_end && left_q > 32'h1)
        begin
          wr_d.data = next_page;
        end
        else
        begin
          wr_d.data = data_addr_q;
        end
      end
      pldw_pkg::PLDW_SEG_LO:
      begin
        wr_d.en   = 1'b1;
        wr_d.addr = wr_addr_q;
        wr_d.data = seg_lo;
      end
      pldw_pkg::PLDW_SEG_HI:
      begin
        wr_d.en   = 1'b1;
        wr_d.addr = wr_addr_q;
        wr_d.data = seg_hi;
      end
      pldw_pkg::PLDW_IDLE,
      pldw_pkg::PLDW_FINISH:
      begin
        wr_d.en = 1'b0;
      end
    endcase
  end

  // Walk state machine
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= pldw_pkg::PLDW_IDLE;
    end
    else
    begin
      unique case (state_q)
        pldw_pkg::PLDW_IDLE:
        begin
          if (start)
          begin
            if (err_s != pldw_pkg::ERR_NONE)
            begin
              state_q <= pldw_pkg::PLDW_FINISH;
            end
            else if (req.mode == pldw_pkg::PLDW_MODE_SCATTER)
            begin
              state_q <= pldw_pkg::PLDW_SEG_LO;
            end
            else if (pages_s > 64'h2)
            begin
              state_q <= pldw_pkg::PLDW_LIST;
            end
            else
            begin
              state_q <= pldw_pkg::PLDW_FINISH;
            end
          end
        end
        pldw_pkg::PLDW_LIST:
        begin
          if (!(at_end && left_q > 32'h1) && left_q == 32'h1)
          begin
            state_q <= pldw_pkg::PLDW_FINISH;
          end
        end
        pldw_pkg::PLDW_SEG_LO:
        begin
          state_q <= pldw_pkg::PLDW_SEG_HI;
        end
        pldw_pkg::PLDW_SEG_HI:
        begin
          // Single segment with no chaining inside, so the device sees it as last
          state_q <= (rem_q == cur_len) ? pldw_pkg::PLDW_FINISH : pldw_pkg::PLDW_SEG_LO;
        end
        pldw_pkg::PLDW_FINISH:
        begin
          state_q <= pldw_pkg::PLDW_IDLE;
        end
      endcase
    end
  end

  // Request capture and page geometry
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      req_q  <= '0;
      page_q <= 64'h0;
      mask_q <= 64'h0;
    end
    else if (state_q == pldw_pkg::PLDW_IDLE && start)
    begin
      req_q  <= req;
      page_q <= page_s;
      mask_q <= mask_s;
    end
  end

  // Write pointer, data pointer and counters
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_addr_q   <= 64'h0;
      data_addr_q <= 64'h0;
      left_q      <= 32'h0;
      rem_q       <= 32'h0;
    end
    else
    begin
      unique case (state_q)
        pldw_pkg::PLDW_IDLE:
        begin
          if (start && req.mode == pldw_pkg::PLDW_MODE_PAGE)
          begin
            wr_addr_q   <= req.list_base;
            data_addr_q <= base_s + page_s;
            left_q      <= pages_s[31:0] - 32'h1;
          end
          else if (start)
          begin
            wr_addr_q   <= req.seg_base;
            // Zero length gives one null descriptor
            data_addr_q <= (req.length == 32'h0) ? 64'h0 : req.buf_addr;
            rem_q       <= req.length;
          end
        end
        pldw_pkg::PLDW_LIST:
        begin
          if (at_end && left_q > 32'h1)
          begin
            wr_addr_q <= next_page;
          end
          else
          begin
            wr_addr_q   <= wr_addr_q + 64'(pldw_pkg::QWORD_BYTES);
            data_addr_q <= data_addr_q + page_q;
            left_q      <= left_q - 32'h1;
          end
        end
        pldw_pkg::PLDW_SEG_LO:
        begin
          wr_addr_q <= wr_addr_q + 64'(pldw_pkg::QWORD_BYTES);
        end
        pldw_pkg::PLDW_SEG_HI:
        begin
          // Any byte address and length; chunks only bound each descriptor
          wr_addr_q   <= wr_addr_q + 64'(pldw_pkg::QWORD_BYTES);
          data_addr_q <= data_addr_q + {32'h0, cur_len};
          rem_q       <= rem_q - cur_len;
        end
        pldw_pkg::PLDW_FINISH:
        begin
          left_q <= 32'h0;
        end
      endcase
    end
  end

  // Command slots, entry count and completion status
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      slot1_q <= 64'h0;
      slot2_q <= 64'h0;
      count_q <= 32'h0;
      err_q   <= pldw_pkg::ERR_NONE;
    end
    else if (state_q == pldw_pkg::PLDW_IDLE && start)
    begin
      err_q <= err_s;
      if (err_s != pldw_pkg::ERR_NONE)
      begin
        slot1_q <= 64'h0;
        slot2_q <= 64'h0;
        count_q <= 32'h0;
      end
      else if (req.mode == pldw_pkg::PLDW_MODE_SCATTER)
      begin
        slot1_q <= cmd_lo;
        slot2_q <= cmd_hi;
        count_q <= ndesc_w;
      end
      else
      begin
        slot1_q <= req.buf_addr;
        count_q <= pages_s[31:0];
        if (pages_s == 64'h1)
        begin
          slot2_q <= 64'h0;
        end
        else if (pages_s == 64'h2)
        begin
          slot2_q <= base_s + page_s;
        end
        else
        begin
          slot2_q <= req.list_base;
        end
      end
    end
  end

  // Handshake flags
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (state_q == pldw_pkg::PLDW_FINISH);
      busy_q <= (state_q == pldw_pkg::PLDW_IDLE) ? start : (state_q != pldw_pkg::PLDW_FINISH);
    end
  end

  // Host memory image; index wraps, so lists must fit in the window
  pldw_mem #(
    .DATA_W (pldw_pkg::ENTRY_W),
    .IDX_W  (MEM_IDX_W)
  ) u_mem (
    .clk       (clk),
    .wr_en     (wr_d.en),
    .wr_idx    (wr_d.addr[MEM_IDX_W+2:3]),
    .wr_data   (wr_d.data),
    .rd_en     (rd_en),
    .rd_idx    (rd_idx),
    .rd_data_q (rd_data_q)
  );

endmodule
`default_nettype wire

// file: testbench/pldw_builder_monitor.sv
// Checker on the builder's status and command slot ports
`timescale 1ns/100ps
`default_nettype none
module pldw_builder_monitor #(
  parameter int unsigned MEM_IDX_W   = 10,
  parameter int unsigned CHUNK_SHIFT = 12
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Request and status
  input wire logic        start,
  input wire logic        busy_q,
  input wire logic        done_q,
  input wire logic [2:0]  err_q,
  input wire logic [31:0] count_q,
  // Command slots
  input wire logic [63:0] slot1_q,
  input wire logic [63:0] slot2_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Handshake; the done cycle is skipped, though the builder is already idle then and takes its start
  a_start_gets_busy: assert property (start && !busy_q && !done_q |=> busy_q)
    else $error("idle start not taken");
  a_done_one_cycle: assert property (done_q |=> !done_q)
    else $error("done longer than one cycle");
  a_busy_ends_done: assert property ($fell(busy_q) |-> done_q)
    else $error("busy fell without done");
  // Refused requests finish at once and write nothing
  a_err_fast_done: assert property ($rose(busy_q) && err_q != 3'h0 |=> done_q)
    else $error("error build not finished next cycle");
  a_err_no_slots: assert property (done_q && err_q != 3'h0 |-> slot1_q == 64'h0 && slot2_q == 64'h0)
    else $error("slots written on error");
  // Results stand while idle
  a_slots_stand: assert property (!busy_q && !start |=> $stable(slot1_q) && $stable(slot2_q) && $stable(count_q) && $stable(err_q))
    else $error("results changed while idle");
  a_slot2_aligned: assert property (done_q |-> slot2_q[2:0] == 3'h0)
    else $error("second slot not qword aligned");
  a_slot1_reserved: assert property (done_q && err_q == 3'h0 |-> slot1_q[1:0] == 2'h0)
    else $error("reserved bits set in first slot");
  a_count_set: assert property (done_q && err_q == 3'h0 |-> count_q != 32'h0)
    else $error("good build with zero count");

  c_err_done: cover property (done_q && err_q != 3'h0);
  c_list_done: cover property (done_q && count_q > 32'h2);
  c_refused: cover property (busy_q && start);
endmodule

bind pldw_builder pldw_builder_monitor #(.MEM_IDX_W(MEM_IDX_W), .CHUNK_SHIFT(CHUNK_SHIFT)) mon_u (
  .clk(clk), .nrst(nrst), .start(start), .busy_q(busy_q), .done_q(done_q),
  .err_q(err_q), .count_q(count_q), .slot1_q(slot1_q), .slot2_q(slot2_q));
`default_nettype wire

// file: testbench/pldw_dev_model.sv
// Device-side fetcher that reads host memory and decodes entries
`timescale 1ns/100ps
`default_nettype none
module pldw_dev_model #(
  parameter int unsigned MEM_IDX_W  = 10,
  parameter int unsigned PAGE_SHIFT = 12
) (
  // Clock
  input  wire logic                 clk,
  // Memory read port
  output logic                      rd_en,
  output logic [MEM_IDX_W-1:0]      rd_idx,
  input  wire logic [63:0]          rd_data_q,
  // Decode of the last fetched qword
  output logic [63:0]               got_q,
  output logic [3:0]                type_code,
  output logic                      type_bad,
  output logic                      sub_bad,
  output logic                      ofs_bad
);
  initial
  begin
    rd_en  = 1'b0;
    rd_idx = '0;
    got_q  = 64'h0;
  end

  // Request held over its sampling edge; data taken one cycle later
  task automatic fetch(input logic [63:0] addr, output logic [63:0] data);
    @(negedge clk);
    rd_en  = 1'b1;
    rd_idx = addr[MEM_IDX_W+2:3];
    @(negedge clk);
    rd_en  = 1'b0;
    rd_idx = ~rd_idx; // Released index shows no stale value
    got_q  = rd_data_q;
    data   = rd_data_q;
  endtask

  // Identifier byte decode; vendor code unsupported here
  assign type_code = got_q[63:60];
  assign type_bad  = (type_code > pldw_pkg::TYPE_LAST);
  assign sub_bad   = (type_code == pldw_pkg::TYPE_DATA) && (got_q[59:56] != 4'h0);
  // Offset runs from bit 2 up to the page boundary
  assign ofs_bad   = |got_q[PAGE_SHIFT-1:2];
endmodule
`default_nettype wire

// file: testbench/page_list_descriptor_walker_tb_top.sv
// Self-checking bench for the page list and descriptor builder
`timescale 1ns/100ps
`default_nettype none
module page_list_descriptor_walker_tb_top;
  logic                clk;
  logic                nrst;
  logic                start;
  pldw_pkg::pldw_req_s req;
  logic                busy_q;
  logic                done_q;
  logic [2:0]          err_q;
  logic [31:0]         count_q;
  logic [63:0]         slot1_q;
  logic [63:0]         slot2_q;
  logic [63:0]         rd_data_q;
  logic                rd_en;
  logic [9:0]          rd_idx;
  logic [3:0]          type_code;
  logic                type_bad;
  logic                sub_bad;
  logic                ofs_bad;
  int                  miscompares;
  int                  comparisons;
  pldw_pkg::pldw_req_s bad_q[5];

  pldw_builder #(.MEM_IDX_W(10), .CHUNK_SHIFT(12)) dut_u (
    .clk(clk), .nrst(nrst), .start(start), .req(req), .busy_q(busy_q), .done_q(done_q),
    .err_q(err_q), .count_q(count_q), .slot1_q(slot1_q), .slot2_q(slot2_q),
    .rd_en(rd_en), .rd_idx(rd_idx), .rd_data_q(rd_data_q));
  pldw_dev_model #(.MEM_IDX_W(10), .PAGE_SHIFT(12)) dev_u (
    .clk(clk), .rd_en(rd_en), .rd_idx(rd_idx), .rd_data_q(rd_data_q), .got_q(),
    .type_code(type_code), .type_bad(type_bad), .sub_bad(sub_bad), .ofs_bad(ofs_bad));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  function automatic pldw_pkg::pldw_req_s mk(input logic m, input logic [63:0] b,
      input logic [31:0] l, input logic [3:0] p, input logic [63:0] lb, input logic [63:0] sb);
    mk = {m, b, l, p, lb, sb};
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One build; twice repeats start during busy with a refused request
  task automatic build(input pldw_pkg::pldw_req_s r, input logic twice);
    int n;
    req   = r;
    start = 1'b1;
    @(negedge clk);
    if (twice)
    begin
      req = bad_q[0];
      @(negedge clk);
    end
    start = 1'b0;
    n = 0;
    while (done_q !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    if (done_q !== 1'b1)
    begin
      miscompares++;
      $display("wrong value at %0t: build never finished", $time);
      tally_and_finish();
    end
    @(negedge clk);
  endtask

  task automatic expect4(input logic [63:0] s1, input logic [63:0] s2, input logic [31:0] c);
    check(slot1_q, s1);
    check(slot2_q, s2);
    check(64'(count_q), 64'(c));
    check(64'(err_q), 64'h0);
  endtask

  task automatic peek(input logic [63:0] a, input logic [63:0] exp);
    logic [63:0] d;
    dev_u.fetch(a, d);
    check(d, exp);
  endtask

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    start = 1'b0;
    req = '0;
    miscompares = 0;
    comparisons = 0;
    bad_q[0] = mk(1'b0, 64'h1011, 32'h40, 4'h0, 64'h8000, 64'h0);
    bad_q[1] = mk(1'b0, 64'h1000, 32'h0, 4'h0, 64'h8000, 64'h0);
    bad_q[2] = mk(1'b0, 64'h1000, 32'h3000, 4'h0, 64'h8004, 64'h0);
    bad_q[3] = mk(1'b1, 64'h1000, 32'h40, 4'h0, 64'h0, 64'h104);
    bad_q[4] = mk(1'b1, 64'hFFFF_FFFF_FFFF_FF00, 32'h200, 4'h0, 64'h0, 64'h100);
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    // One page; offset kept in the first slot
    build(mk(1'b0, 64'h1010, 32'h64, 4'h0, 64'h8000, 64'h0), 1'b0);
    expect4(64'h1010, 64'h0, 32'h1);
    // Two pages; second slot page aligned
    build(mk(1'b0, 64'h1010, 32'h1000, 4'h0, 64'h8000, 64'h0), 1'b0);
    expect4(64'h1010, 64'h2000, 32'h2);
    // 8KB pages widen the offset, so no list is needed
    build(mk(1'b0, 64'h1010, 32'h2000, 4'h1, 64'h8000, 64'h0), 1'b0);
    expect4(64'h1010, 64'h2000, 32'h2);
    // Same length at 4KB needs a list of the extra entries only
    build(mk(1'b0, 64'h1010, 32'h2000, 4'h0, 64'h8000, 64'h0), 1'b0);
    expect4(64'h1010, 64'h8000, 32'h3);
    peek(64'h8000, 64'h2000);
    peek(64'h8008, 64'h3000);
    check(64'(ofs_bad), 64'h0);
    // List starts mid-page and chains; a start while busy is ignored
    build(mk(1'b0, 64'h0, 32'h4000, 4'h0, 64'h8FF0, 64'h0), 1'b1);
    expect4(64'h0, 64'h8FF0, 32'h4);
    peek(64'h8FF0, 64'h1000);
    peek(64'h8FF8, 64'h9000);
    peek(64'h9000, 64'h2000);
    peek(64'h9008, 64'h3000);
    // Each refused request reports its code and leaves the slots empty
    for (int i = 0; i < 5; i++)
    begin
      build(bad_q[i], 1'b0);
      check(slot1_q | slot2_q, 64'h0);
      check(64'(err_q), 64'(i + 1));
    end
    // Odd scatter buffer split into packed descriptors of one last segment
    build(mk(1'b1, 64'h1003, 32'h1388, 4'h0, 64'h0, 64'h100), 1'b0);
    expect4(64'h100, 64'h3000_0000_0000_0020, 32'h2);
    peek(64'h100, 64'h1003);
    peek(64'h108, 64'h1000);
    @(posedge clk);
    check(64'({type_bad, sub_bad, type_code}), 64'h0);
    peek(64'h110, 64'h2003);
    peek(64'h118, 64'h388);
    // A last segment may hold no chaining entry at all
    check(64'(type_code >= pldw_pkg::TYPE_CHAIN), 64'h0);
    // Zero length gives one all-zero null descriptor
    build(mk(1'b1, 64'h5000, 32'h0, 4'h0, 64'h0, 64'h200), 1'b0);
    expect4(64'h200, 64'h3000_0000_0000_0010, 32'h1);
    peek(64'h200, 64'h0);
    peek(64'h208, 64'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
